// [common/smx_pkg.sv]
// package: sfr map extension constants and carrier types
package smx_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] SFR_BASE = 8'h80;
    localparam logic [7:0] SFR_LAST = 8'hFF;
    localparam logic [7:0] SYSCON_ADDR = 8'h8F;
    localparam logic [7:0] SYSCON_RESET = 8'h00;
    localparam int MAP_BIT = 0;
    localparam int RSV_RW_BIT = 2;
    localparam logic [7:0] SYSCON_RW_MASK = 8'h05;
    localparam int BANK_DEPTH = 128;
    localparam int IDX_W = 7;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    typedef enum logic {
        SMX_BANK_STD = 1'b0,
        SMX_BANK_MAP = 1'b1
    } smx_bank_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } smx_req_t;
endpackage

// [verilog/smx_bank.sv]
// one bank of 128 special function registers
`timescale 1ns/10ps
module smx_bank (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // synchronised reset, active low
    input wire logic we, // write strobe for this bank
    input wire logic [6:0] idx, // register index within the bank
    input wire logic [7:0] wdata, // write data
    output logic [7:0] rdata // read data at idx, unregistered
);
    logic [7:0] mem_r [0:smx_pkg::BANK_DEPTH-1];

    // plain storage: peripherals behind each location are outside this block
    always_ff @(posedge clk_sys) begin
        if (we && rst_n) begin
            mem_r[idx] <= wdata;
        end
    end

    // read is combinational so the top can register the byte once, on its own output
    assign rdata = mem_r[idx];
endmodule

// [verilog/smx_sfr_map.sv]
// sfr address decode with standard / mapped bank extension
`timescale 1ns/10ps
// Function
// - registers decode only for direct addresses 80 to FF hex.
// - all processor state except the program counter lives as registers in that region.
// - two banks, standard and mapped, each cover 80 to FF hex.
// - bank choice comes only from the stored map-select bit, never from the address.
// - map-select is bit 0, read-write, 0 standard and 1 mapped.
// - the control register sits at 8F hex and resets to zero.
// - bit 2 of the control register is reserved read-write and returns the last write.
// - bits 1 and 7 to 3 of the control register read as zero.
module smx_sfr_map (
    input wire logic clk_sys, // system clock, 50 MHz
    input wire logic rstn, // asynchronous reset, active low
    input wire smx_pkg::smx_req_t req, // direct access from cpu core
    output logic [7:0] rdata, // read data, valid the cycle after rd
    output logic rvalid, // one-cycle pulse with rdata
    output logic sfr_hit, // registered: last request decoded as sfr
    output logic bank_map_select // registered map-select level
);
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_s1_r;
    logic rst_n;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_s1_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
        end
    end

    // second stage is the only reader of the first, the rest sees rst_n
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_n <= 1'b0;
        end else begin
            rst_n <= rst_s1_r;
        end
    end

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic in_sfr;
    logic is_ctrl;
    logic rd_hit;
    logic wr_hit;
    logic std_we;
    logic map_we;
    logic ctrl_we;
    logic map_bit_r;
    logic rsv_bit_r;
    logic [7:0] system_control_zero;
    smx_pkg::smx_bank_t bank_sel;
    logic [7:0] std_rdata;
    logic [7:0] map_rdata;
    logic [7:0] rdata_nxt;
    logic rvalid_nxt;
    logic sfr_hit_nxt;

    assign in_sfr = (req.addr >= smx_pkg::SFR_BASE) && (req.addr <= smx_pkg::SFR_LAST);
    assign rd_hit = req.rd && in_sfr;
    assign wr_hit = req.wr && in_sfr;
    assign is_ctrl = in_sfr && (req.addr == smx_pkg::SYSCON_ADDR);
    // bank comes from the stored bit only, so the address cannot steer it
    assign bank_sel = smx_pkg::smx_bank_t'(map_bit_r);

    // control register is shadowed out of both banks so software can always return
    always_comb begin
        std_we = 1'b0;
        map_we = 1'b0;
        ctrl_we = 1'b0;
        if (wr_hit) begin
            if (is_ctrl) begin
                ctrl_we = 1'b1;
            end else begin
                case (bank_sel)
                    smx_pkg::SMX_BANK_STD: begin
                        std_we = 1'b1;
                    end
                    smx_pkg::SMX_BANK_MAP: begin
                        map_we = 1'b1;
                    end
                    default: begin
                        std_we = 1'b0;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            map_bit_r <= smx_pkg::SYSCON_RESET[smx_pkg::MAP_BIT];
        end else if (ctrl_we) begin
            map_bit_r <= req.wdata[smx_pkg::MAP_BIT];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rsv_bit_r <= smx_pkg::SYSCON_RESET[smx_pkg::RSV_RW_BIT];
        end else if (ctrl_we) begin
            rsv_bit_r <= req.wdata[smx_pkg::RSV_RW_BIT];
        end
    end

    // bits 1 and 7 to 3 have no storage at all, so they cannot read back non-zero; reserved bit 2 has its own flop
    always_comb begin
        system_control_zero = smx_pkg::ZERO_BYTE;
        system_control_zero[smx_pkg::MAP_BIT] = map_bit_r;
        system_control_zero[smx_pkg::RSV_RW_BIT] = rsv_bit_r;
    end

    // ------------------------------------------------------------
    // banks
    // ------------------------------------------------------------
    smx_bank u_std (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .we(std_we),
        .idx(req.addr[smx_pkg::IDX_W-1:0]),
        .wdata(req.wdata),
        .rdata(std_rdata)
    );

    smx_bank u_map (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .we(map_we),
        .idx(req.addr[smx_pkg::IDX_W-1:0]),
        .wdata(req.wdata),
        .rdata(map_rdata)
    );

    // ------------------------------------------------------------
    // read return
    // ------------------------------------------------------------
    // out-of-range reads return zero; the core's internal ram answers those
    always_comb begin
        rdata_nxt = smx_pkg::ZERO_BYTE;
        if (rd_hit) begin
            if (is_ctrl) begin
                rdata_nxt = system_control_zero;
            end else begin
                case (bank_sel)
                    smx_pkg::SMX_BANK_MAP: begin
                        rdata_nxt = map_rdata;
                    end
                    default: begin
                        rdata_nxt = std_rdata;
                    end
                endcase
            end
        end
    end

    assign rvalid_nxt = req.rd;
    assign sfr_hit_nxt = rd_hit || wr_hit;

    // every output leaves straight from a flop, so the core sees no decode glitches
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= smx_pkg::ZERO_BYTE;
        end else begin
            rdata <= rdata_nxt;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rvalid <= 1'b0;
        end else begin
            rvalid <= rvalid_nxt;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sfr_hit <= 1'b0;
        end else begin
            sfr_hit <= sfr_hit_nxt;
        end
    end

    // mirror of the map bit; a separate flop keeps the pin off the decode fan-out
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bank_map_select <= smx_pkg::SYSCON_RESET[smx_pkg::MAP_BIT];
        end else if (ctrl_we) begin
            bank_map_select <= req.wdata[smx_pkg::MAP_BIT];
        end
    end
endmodule

// [verification/smx_sfr_map_properties.sv]
// sfr map checker
`timescale 1ns/10ps
module smx_sfr_map_properties (
    input wire logic clk_sys, // system clock
    input wire logic rstn, // reset, active low
    input wire logic rvalid, // read return strobe
    input wire logic sfr_hit, // decoded access flag
    input wire logic bank_map_select, // map-select level
    input wire logic [7:0] rdata, // read data
    input wire smx_pkg::smx_req_t req // core access
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    wire logic cw = req.wr && req.addr == 8'h8F;
    property p_rv; req.rd |=> rvalid; endproperty
    a_rv: assert property (p_rv) else $error("rv");
    property p_nr; !req.rd |=> !rvalid; endproperty
    a_nr: assert property (p_nr) else $error("nr");
    property p_ms; !req.addr[7] |=> !sfr_hit; endproperty
    a_ms: assert property (p_ms) else $error("ms");
    property p_ht; req.wr && req.addr[7] |=> sfr_hit; endproperty
    a_ht: assert property (p_ht) else $error("ht");
    property p_lo; req.rd && !req.addr[7] |=> rdata == 8'h00; endproperty
    a_lo: assert property (p_lo) else $error("lo");
    property p_sl; cw |=> bank_map_select == $past(req.wdata[0]); endproperty
    a_sl: assert property (p_sl) else $error("sl");
    property p_kp; !cw |=> $stable(bank_map_select); endproperty
    a_kp: assert property (p_kp) else $error("kp");
    property p_ct; req.rd && req.addr == 8'h8F |=> !(rdata & 8'hFA) && rdata[0] == bank_map_select; endproperty
    a_ct: assert property (p_ct) else $error("ct");
    cover property (cw);
    cover property (req.rd && bank_map_select);
    cover property (req.rd && !req.addr[7]);
endmodule
bind smx_sfr_map smx_sfr_map_properties u_chk (.clk_sys, .rstn, .rvalid, .sfr_hit, .bank_map_select, .rdata, .req);

// [verification/smx_cpu_model.sv]
// cpu model
`timescale 1ns/10ps
module smx_cpu_model (
    input wire logic clk_sys, // clock
    output smx_pkg::smx_req_t req // access
);
    initial req = '0;
    // idle inverts address and data so nothing stale looks held
    task go(smx_pkg::smx_req_t q);
        req <= q.wr || q.rd ? q : {2'b00, ~req.addr, ~req.wdata};
        @(negedge clk_sys);
    endtask
endmodule

// [verification/smx_sfr_map_tb.sv]
// sfr map bench
`timescale 1ns/10ps
module smx_sfr_map_tb;
    logic clk_sys = 1'b0, rstn = 1'b0;
    logic bank_map_select, rvalid, sfr_hit;
    logic [7:0] rdata;
    smx_pkg::smx_req_t req;
    int miscompares = 0, total_checks = 0;
    logic [27:0] rows [9] = '{28'h2805A00, 28'h17F0000, 28'h28FFF00, 28'h280C300, 28'h18000C3,
        28'h28F0400, 28'h180005A, 28'h18F0004, 28'h28F0500};
    smx_cpu_model cpu (.clk_sys, .req);
    smx_sfr_map DUT (.clk_sys, .rstn, .req, .rdata, .rvalid, .sfr_hit, .bank_map_select);
    initial forever #10 clk_sys = ~clk_sys;
    task chk(string n, logic [7:0] s, e);
        total_checks++;
        miscompares += (s !== e);
        if (s !== e) $display("CHECK FAILED %s exp %h got %h", n, e, s);
    endtask
    task end_sim(int t);
        miscompares += t;
        if (miscompares == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial #4000 end_sim(1);
    initial begin
        repeat (10) @(negedge clk_sys);
        rstn = 1'b1;
        repeat (3) @(negedge clk_sys);
        foreach (rows[i]) begin
            cpu.go(rows[i][25:8]);
            chk("rd", rdata, rows[i][7:0]);
            chk("rvalid", {7'h00, rvalid}, {7'h00, rows[i][24]});
            chk("hit", {7'h00, sfr_hit}, {7'h00, (rows[i][25] | rows[i][24]) & rows[i][23]});
        end
        cpu.go(18'h00000);
        rstn = 1'b0;
        @(negedge clk_sys);
        chk("bank", {7'h00, bank_map_select}, 8'h00);
        repeat (9) @(negedge clk_sys);
        rstn = 1'b1;
        repeat (3) @(negedge clk_sys);
        cpu.go(18'h18F00);
        chk("ctl", rdata, 8'h00);
        cpu.go(18'h18000);
        chk("keep", rdata, 8'h5A);
        end_sim(0);
    end
endmodule
